// ### rtl/srfp_pkg.sv
package srfp_pkg;

   localparam int NUM_SLAVES = 4;
   localparam int SEL_W = 2;
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int HDR_WORDS = 4;
   localparam int FIFO_DEPTH = 16;
   localparam int SEQ_W = 16;
   localparam int TS_W = 32;

   // header type word layout
   localparam logic [15:0] HDR_TYPE_BASE = 16'h0001;
   localparam int HDR_RAW_BIT = 1;

   // timestamp tick: one thousand cycles of a 100 ns reference clock
   localparam int REF_CLK_NS = 100;
   localparam int TICK_REF_CYCLES = 1000;
   localparam int TICK_TIME_NS = REF_CLK_NS * TICK_REF_CYCLES;
   localparam int CLK_PERIOD_PS = 4000;
   localparam int TICK_CYCLES = (TICK_TIME_NS * 1000) / CLK_PERIOD_PS;

   // reset values
   localparam logic [SEQ_W-1:0] SEQ_RESET = 16'h0000;
   localparam logic [TS_W-1:0] TS_RESET = 32'h0000_0000;

   // byte shifter states
   typedef enum logic [2:0]
   {
      SH_EMPTY = 3'b001,
      SH_LOW = 3'b010,
      SH_HIGH = 3'b100
   } srfp_shift_e;

endpackage

// ### rtl/srfp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module srfp_fifo
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
)
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // status
   output logic full,
   output logic empty
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [CW-1:0] count;
   logic do_wr;
   logic do_rd;

   assign full = (count == CW'(DEPTH));
   assign empty = (count == '0);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = mem[rd_ptr];
   assign do_wr = in_valid & ~full;
   assign do_rd = out_ready & ~empty;

   always_ff @(posedge clk)
   begin
      if (do_wr)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (do_wr)
         begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
         end
         if (do_rd)
         begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
         end
         if (do_wr && !do_rd)
         begin
            count <= count + CW'(1);
         end
         else if (do_rd && !do_wr)
         begin
            count <= count - CW'(1);
         end
      end
   end

endmodule
`default_nettype wire

// ### rtl/srfp_frame_packer.sv
`timescale 1ns/1ps
`default_nettype none
module srfp_frame_packer
#(
   parameter int TICK_CYCLES = srfp_pkg::TICK_CYCLES,
   parameter int FIFO_DEPTH = srfp_pkg::FIFO_DEPTH
)
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // slave fpgas
   input wire logic [srfp_pkg::NUM_SLAVES-1:0] slave_empty,
   input wire logic [srfp_pkg::NUM_SLAVES-1:0][srfp_pkg::WORD_W-1:0] slave_data,
   output logic [srfp_pkg::NUM_SLAVES-1:0] slave_read,
   // state generator controls
   input wire logic frame_start,
   input wire logic raw_mode,
   input wire logic [srfp_pkg::SEL_W-1:0] dump_slave,
   input wire logic scan_cmd,
   input wire logic scan_begin,
   // usb byte output
   input wire logic usb_room,
   output logic usb_write,
   output logic [srfp_pkg::BYTE_W-1:0] usb_data,
   output logic usb_flush,
   // status
   output logic frame_active,
   output logic buffer_empty,
   output logic [srfp_pkg::SEL_W-1:0] selected_slave,
   output logic [srfp_pkg::SEQ_W-1:0] scan_seq,
   output logic [srfp_pkg::TS_W-1:0] timestamp
);

   localparam int PS_W = $clog2(TICK_CYCLES);
   localparam int HC_W = $clog2(srfp_pkg::HDR_WORDS + 1);

   // selector
   logic [srfp_pkg::SEL_W-1:0] prio_sel;
   logic [srfp_pkg::SEL_W-1:0] sel;
   logic sel_empty;

   // frame delimiter
   logic start_q;
   logic start_rise;
   logic frame_end;
   logic next_frame;
   logic frame_open;

   // reader and data fifo
   logic read_strobe;
   logic [srfp_pkg::WORD_W-1:0] read_word;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [srfp_pkg::WORD_W-1:0] fifo_out_data;
   logic fifo_full;
   logic fifo_empty;

   // header register
   logic [srfp_pkg::WORD_W-1:0] hdr_word [srfp_pkg::HDR_WORDS];
   logic [HC_W-1:0] hdr_left;
   logic hdr_pop;

   // virtual output fifo
   logic vout_valid;
   logic vout_ready;
   logic [srfp_pkg::WORD_W-1:0] vout_data;

   // byte shifter
   srfp_pkg::srfp_shift_e sh_state;
   logic [srfp_pkg::WORD_W-1:0] sh_word;
   logic flush_pending;
   logic flush_due;

   // timestamp prescaler
   logic [PS_W-1:0] tick_cnt;
   logic tick;

   // slave selector: priority on inverted empties, overridden in raw mode
   always_comb
   begin
      prio_sel = '0;
      for (int i = 0; i < srfp_pkg::NUM_SLAVES; i++)
      begin
         if (!slave_empty[i])
         begin
            prio_sel = srfp_pkg::SEL_W'(i);
         end
      end
   end

   assign sel = raw_mode ? dump_slave : prio_sel;
   // in normal mode all slaves empty gives slave 0, whose empty is then high
   assign sel_empty = slave_empty[sel];
   assign selected_slave = sel;

   // frame delimiter
   assign start_rise = frame_start & ~start_q;
   assign buffer_empty = (hdr_left == '0) & fifo_empty & (sh_state == srfp_pkg::SH_EMPTY)
      & ~flush_pending;
   assign frame_end = sel_empty | fifo_full;

   always_comb
   begin
      if (frame_end)
      begin
         next_frame = 1'b0;
      end
      else if (start_rise && buffer_empty)
      begin
         next_frame = 1'b1;
      end
      else
      begin
         next_frame = frame_active;
      end
   end

   assign frame_open = next_frame & ~frame_active;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         start_q <= 1'b0;
      end
      else
      begin
         start_q <= frame_start;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         frame_active <= 1'b0;
      end
      else
      begin
         frame_active <= next_frame;
      end
   end

   // slave reader: strobe demux and data mux
   // slaves present their word combinationally; the strobe pops it
   assign read_strobe = frame_active & ~sel_empty & fifo_in_ready;

   always_comb
   begin
      slave_read = '0;
      slave_read[sel] = read_strobe;
   end

   assign read_word = slave_data[sel];

   srfp_fifo
   #(
      .WIDTH(srfp_pkg::WORD_W),
      .DEPTH(FIFO_DEPTH)
   )
   data_fifo
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(read_strobe),
      .in_ready(fifo_in_ready),
      .in_data(read_word),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data),
      .full(fifo_full),
      .empty(fifo_empty)
   );

   // header register: loads on frame rise, shifts out one word per pop
   assign hdr_pop = vout_ready & (hdr_left != '0);

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         hdr_left <= '0;
      end
      else if (frame_open)
      begin
         hdr_left <= HC_W'(srfp_pkg::HDR_WORDS);
      end
      else if (hdr_pop)
      begin
         hdr_left <= hdr_left - HC_W'(1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < srfp_pkg::HDR_WORDS; i++)
         begin
            hdr_word[i] <= '0;
         end
      end
      else if (frame_open)
      begin
         hdr_word[0] <= srfp_pkg::HDR_TYPE_BASE;
         hdr_word[0][srfp_pkg::HDR_RAW_BIT] <= raw_mode;
         hdr_word[1] <= scan_seq;
         hdr_word[2] <= timestamp[15:0];
         hdr_word[3] <= timestamp[31:16];
      end
      else if (hdr_pop)
      begin
         for (int i = 0; i < srfp_pkg::HDR_WORDS - 1; i++)
         begin
            hdr_word[i] <= hdr_word[i + 1];
         end
         hdr_word[srfp_pkg::HDR_WORDS - 1] <= '0;
      end
   end

   // virtual fifo: header words first, then buffered slave data
   assign vout_valid = (hdr_left != '0) | fifo_out_valid;
   assign vout_data = (hdr_left != '0) ? hdr_word[0] : fifo_out_data;
   assign vout_ready = (sh_state == srfp_pkg::SH_EMPTY) & vout_valid;
   assign fifo_out_ready = vout_ready & (hdr_left == '0);

   // byte shifter: low byte first, a load cycle per word, then one byte per cycle while usb has room
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sh_state <= srfp_pkg::SH_EMPTY;
         sh_word <= '0;
         usb_write <= 1'b0;
         usb_data <= '0;
      end
      else
      begin
         usb_write <= 1'b0;
         case (sh_state)
            srfp_pkg::SH_EMPTY:
            begin
               if (vout_ready)
               begin
                  sh_word <= vout_data;
                  sh_state <= srfp_pkg::SH_LOW;
               end
            end
            srfp_pkg::SH_LOW:
            begin
               if (usb_room)
               begin
                  usb_write <= 1'b1;
                  usb_data <= sh_word[7:0];
                  sh_state <= srfp_pkg::SH_HIGH;
               end
            end
            srfp_pkg::SH_HIGH:
            begin
               if (usb_room)
               begin
                  usb_write <= 1'b1;
                  usb_data <= sh_word[15:8];
                  sh_state <= srfp_pkg::SH_EMPTY;
               end
            end
            default:
            begin
               sh_state <= srfp_pkg::SH_EMPTY;
            end
         endcase
      end
   end

   // flush once per frame after the last byte has been written
   assign flush_due = flush_pending & ~frame_active & ~vout_valid
      & (sh_state == srfp_pkg::SH_EMPTY) & ~usb_write;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         flush_pending <= 1'b0;
      end
      else if (frame_open)
      begin
         flush_pending <= 1'b1;
      end
      else if (flush_due)
      begin
         flush_pending <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         usb_flush <= 1'b0;
      end
      else
      begin
         usb_flush <= flush_due;
      end
   end

   // scan sequence counter
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         scan_seq <= srfp_pkg::SEQ_RESET;
      end
      else if (scan_cmd)
      begin
         scan_seq <= scan_seq + srfp_pkg::SEQ_W'(1);
      end
   end

   // timestamp prescaler and counter
   assign tick = (tick_cnt == PS_W'(TICK_CYCLES - 1));

   always_ff @(posedge clk)
   begin
      if (sys_rst || scan_begin)
      begin
         tick_cnt <= '0;
      end
      else if (tick)
      begin
         tick_cnt <= '0;
      end
      else
      begin
         tick_cnt <= tick_cnt + PS_W'(1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || scan_begin)
      begin
         timestamp <= srfp_pkg::TS_RESET;
      end
      else if (tick)
      begin
         timestamp <= timestamp + srfp_pkg::TS_W'(1);
      end
   end

endmodule
`default_nettype wire

// ### testbench/srfp_props.sv
`timescale 1ns/1ps
`default_nettype none
module srfp_props
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // watched ports
   input wire logic [3:0] slave_empty,
   input wire logic [3:0] slave_read,
   input wire logic frame_start,
   input wire logic raw_mode,
   input wire logic [1:0] dump_slave,
   input wire logic scan_cmd,
   input wire logic scan_begin,
   input wire logic usb_room,
   input wire logic usb_write,
   input wire logic usb_flush,
   input wire logic frame_active,
   input wire logic buffer_empty,
   input wire logic [1:0] selected_slave,
   input wire logic [15:0] scan_seq,
   input wire logic [31:0] timestamp
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   prio_top_a: assert property (!raw_mode && !slave_empty[3] |-> selected_slave == 2'h3)
      else $error("slave 3 not chosen first");
   raw_pick_a: assert property (raw_mode |-> selected_slave == dump_slave)
      else $error("raw mode selection wrong");
   read_route_a: assert property (slave_read != 0 |-> slave_read == 4'h1 << selected_slave)
      else $error("read strobe misrouted");
   read_gate_a: assert property (slave_read != 0 |-> frame_active && !slave_empty[selected_slave])
      else $error("read outside frame or from empty slave");
   end_drop_a: assert property (frame_active && slave_empty[selected_slave] |=> !frame_active)
      else $error("frame did not drop on end");
   busy_refuse_a: assert property (!buffer_empty && !frame_active |=> !frame_active)
      else $error("frame opened with buffer busy");
   rise_open_a: assert property ($rose(frame_start) && buffer_empty &&
      !slave_empty[selected_slave] |=> frame_active)
      else $error("frame not opened on rise");
   byte_room_a: assert property (usb_write |-> $past(usb_room))
      else $error("byte sent without room");
   flush_pulse_a: assert property (usb_flush |-> !frame_active ##1 !usb_flush)
      else $error("flush not a single pulse");
   seq_inc_a: assert property (scan_cmd |=> scan_seq == $past(scan_seq) + 16'h0001)
      else $error("scan sequence did not step");
   ts_clear_a: assert property (scan_begin |=> timestamp == 32'h0000_0000)
      else $error("timestamp not cleared");
endmodule
bind srfp_frame_packer srfp_props u_props
(
   .clk(clk), .sys_rst(sys_rst), .slave_empty(slave_empty), .slave_read(slave_read),
   .frame_start(frame_start), .raw_mode(raw_mode), .dump_slave(dump_slave),
   .scan_cmd(scan_cmd), .scan_begin(scan_begin), .usb_room(usb_room),
   .usb_write(usb_write), .usb_flush(usb_flush), .frame_active(frame_active),
   .buffer_empty(buffer_empty), .selected_slave(selected_slave),
   .scan_seq(scan_seq), .timestamp(timestamp)
);
`default_nettype wire

// ### testbench/srfp_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module srfp_slave_model
(
   input wire logic clk,
   input wire logic [3:0] slave_read,
   output logic [3:0] slave_empty,
   output logic [3:0][15:0] slave_data
);
   int cnt [4] = '{0, 0, 0, 0};
   logic [15:0] last [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
   // words waiting after an integration period
   task automatic load(input int s, input int n);
      cnt[s] = n;
   endtask
   // a spent slave shows the inverse of its last word
   always_comb
   begin
      for (int s = 0; s < 4; s++)
      begin
         slave_empty[s] = cnt[s] == 0;
         slave_data[s] = cnt[s] == 0 ? ~last[s] : 16'hA000 | 16'(s << 8) | 16'(cnt[s]);
      end
   end
   always @(posedge clk)
   begin
      for (int s = 0; s < 4; s++)
      begin
         if (slave_read[s] && cnt[s] > 0)
         begin
            last[s] <= slave_data[s];
            cnt[s] <= cnt[s] - 1;
         end
      end
   end
endmodule
`default_nettype wire

// ### testbench/srfp_frame_packer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module srfp_frame_packer_bench;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic frame_start = 1'b0;
   logic raw_mode = 1'b0;
   logic [1:0] dump_slave = 2'h0;
   logic scan_cmd = 1'b0;
   logic scan_begin = 1'b0;
   logic usb_room = 1'b0;
   logic stall = 1'b0;
   logic [3:0] slave_empty, slave_read;
   logic [3:0][15:0] slave_data;
   logic usb_write, usb_flush, frame_active, buffer_empty;
   logic [7:0] usb_data;
   logic [1:0] selected_slave;
   logic [15:0] scan_seq;
   logic [31:0] timestamp;
   logic [7:0] got [$];
   logic [15:0] want [$];
   int flushes = 0;
   int miscompares = 0;
   int checks_done = 0;
   always #2 clk = ~clk;
   // room every other cycle unless stalled
   always @(posedge clk)
      usb_room <= stall ? 1'b0 : ~usb_room;
   always @(posedge clk)
   begin
      if (usb_write)
         got.push_back(usb_data);
      if (usb_flush)
         flushes++;
   end
   srfp_frame_packer #(.TICK_CYCLES(10), .FIFO_DEPTH(16)) uut
   (
      .clk(clk), .sys_rst(sys_rst), .slave_empty(slave_empty), .slave_data(slave_data),
      .slave_read(slave_read), .frame_start(frame_start), .raw_mode(raw_mode),
      .dump_slave(dump_slave), .scan_cmd(scan_cmd), .scan_begin(scan_begin),
      .usb_room(usb_room), .usb_write(usb_write), .usb_data(usb_data),
      .usb_flush(usb_flush), .frame_active(frame_active), .buffer_empty(buffer_empty),
      .selected_slave(selected_slave), .scan_seq(scan_seq), .timestamp(timestamp)
   );
   srfp_slave_model slaves
   (
      .clk(clk), .slave_read(slave_read), .slave_empty(slave_empty), .slave_data(slave_data)
   );
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [15:0] wd(input int s, input int k);
      return 16'hA000 | 16'(s << 8) | 16'(k);
   endfunction
   task automatic tally_and_finish();
      if (miscompares == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // opens with timestamp held clear
   task automatic open_frame();
      @(posedge clk) scan_begin <= 1'b1;
      @(posedge clk) frame_start <= 1'b1;
      @(posedge clk) scan_begin <= 1'b0;
      frame_start <= 1'b0;
      #1 chk("frame_active", frame_active, 1);
   endtask
   task automatic finish_frame();
      int f;
      f = flushes;
      for (int i = 0; i < 3000 && flushes == f; i++)
         @(posedge clk);
      #1 chk("flushes", flushes, f + 1);
      chk("byte count", got.size(), 2 * want.size());
      foreach (want[i])
         chk("stream word", {got[2 * i + 1], got[2 * i]}, want[i]);
      chk("buffer_empty", buffer_empty, 1);
      got.delete();
   endtask
   task automatic t_tick();
      @(posedge clk) scan_begin <= 1'b1;
      @(posedge clk) scan_begin <= 1'b0;
      repeat (35) @(posedge clk);
      #1 chk("timestamp", timestamp, 3);
   endtask
   task automatic t_normal();
      slaves.load(3, 2);
      slaves.load(2, 1);
      slaves.load(0, 2);
      @(posedge clk) scan_cmd <= 1'b1;
      repeat (2) @(posedge clk);
      scan_cmd <= 1'b0;
      want = {16'h0001, 16'h0002, 16'h0000, 16'h0000, wd(3, 2), wd(3, 1), wd(2, 1), wd(0, 2),
         wd(0, 1)};
      open_frame();
      for (int i = 0; i < 50 && frame_active; i++)
         @(posedge clk);
      frame_start <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("refused start", frame_active, 0);
      @(posedge clk) frame_start <= 1'b0;
      finish_frame();
   endtask
   task automatic t_raw();
      slaves.load(1, 3);
      slaves.load(3, 5);
      @(posedge clk) raw_mode <= 1'b1;
      dump_slave <= 2'h1;
      scan_cmd <= 1'b1;
      @(posedge clk) scan_cmd <= 1'b0;
      want = {16'h0003, 16'h0003, 16'h0000, 16'h0000, wd(1, 3), wd(1, 2), wd(1, 1)};
      open_frame();
      chk("selected_slave", selected_slave, 1);
      finish_frame();
      @(posedge clk) raw_mode <= 1'b0;
   endtask
   task automatic t_full();
      @(posedge clk) stall <= 1'b1;
      slaves.load(3, 20);
      want = {16'h0001, 16'h0003, 16'h0000, 16'h0000};
      for (int k = 20; k > 4; k--)
         want.push_back(wd(3, k));
      open_frame();
      repeat (30) @(posedge clk);
      #1 chk("full stop", frame_active, 0);
      chk("words left", slaves.cnt[3], 4);
      @(posedge clk) stall <= 1'b0;
      finish_frame();
   endtask
   initial
   begin
      #40000;
      miscompares++;
      tally_and_finish();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      #1 chk("reset empty", buffer_empty, 1);
      chk("reset seq", scan_seq, 0);
      t_tick();
      t_normal();
      t_raw();
      t_full();
      tally_and_finish();
   end
endmodule
`default_nettype wire
